// ===== logic/aabe_exec.sv
// Execution unit: arithmetic, logic, multiply, compare, skip, jump,
// call, return and conditional branch instructions of an 8-bit core.
// Assumes the fetch stage and register file share ref_clk, hold a
// request stable while req_valid is high, and apply the results.
//
// Overview of operation
// - Add registers, optional carry, five flags
// - Subtract register or constant, optional carry
// - Word add/subtract immediate, two cycles
// - AND, OR, XOR set only Z,N,V
// - Set or clear bits by constant mask
// - Test register against itself, flags only
// - Multiply unsigned/signed/mixed into R1:R0, two cycles
// - Fractional multiply shifts product left once
// - Pointer jump loads PC from Z
// - Calls: relative/pointer three, direct four cycles
// - Compare equal skips next instruction
// - Compares update flags, store nothing
// - Skip on working register bit state
// - Skip on I/O register bit state
// - Status bit branch adds offset plus one
// - Signed branches use N xor V
// - Unsigned branches use carry flag
// - Half-carry branches on H flag
`timescale 1ns/1ps

module aabe_exec (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire logic                req_valid,
	input  wire aabe_pkg::aabe_req_t req,
	output logic                     req_ready,
	output aabe_pkg::aabe_rsp_t      rsp,
	output aabe_pkg::aabe_status_t   status,
	input  wire logic [1:0]          reg_addr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [7:0]               reg_rdata
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic aabe_pkg::aabe_arith_t add8(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic       ci
	);
		aabe_pkg::aabe_arith_t o;
		logic [8:0]            s;
		s = {1'h0, a} + {1'h0, b} + {8'h00, ci};
		o.res = s[7:0];
		o.c = s[8];
		o.h = (a[3] & b[3]) | (b[3] & ~o.res[3]) | (~o.res[3] & a[3]);
		o.v = (a[7] & b[7] & ~o.res[7]) | (~a[7] & ~b[7] & o.res[7]);
		return o;
	endfunction

	function automatic aabe_pkg::aabe_arith_t sub8(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic       ci
	);
		aabe_pkg::aabe_arith_t o;
		logic [8:0]            s;
		s = {1'h0, a} - {1'h0, b} - {8'h00, ci};
		o.res = s[7:0];
		o.c = s[8];
		o.h = (~a[3] & b[3]) | (b[3] & o.res[3]) | (o.res[3] & ~a[3]);
		o.v = (a[7] & ~b[7] & ~o.res[7]) | (~a[7] & b[7] & o.res[7]);
		return o;
	endfunction

	aabe_pkg::aabe_state_t st_q;
	aabe_pkg::aabe_state_t st_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		aabe_pkg::aabe_arith_t  ar;
		aabe_pkg::aabe_status_t sr;
		aabe_pkg::aabe_rsp_t    rs;
		aabe_pkg::aabe_exec_t   ex;
		logic [7:0]             sv;
		logic [7:0]             res;
		logic [2:0]             cyc;
		logic [15:0]            wsum;
		logic [17:0]            prod;
		logic [8:0]             ma;
		logic [8:0]             mb;
		logic                   signed_a;
		logic                   signed_b;
		logic                   frac;
		logic                   take;
		logic                   skip;
		logic [15:0]            pc1;
		logic [15:0]            rel;
		logic [15:0]            skip_pc;
		logic [2:0]             skip_cyc;
		logic                   commit;

		st_d = st_q;
		ar = '0;
		sr = st_q.status;
		rs = '0;
		ex = '0;
		sv = st_q.status;
		res = aabe_pkg::BYTE_ZERO;
		cyc = aabe_pkg::CYC_ONE;
		wsum = aabe_pkg::WORD_ZERO;
		prod = '0;
		ma = '0;
		mb = '0;
		signed_a = 1'h0;
		signed_b = 1'h0;
		frac = 1'h0;
		take = 1'h0;
		skip = 1'h0;
		commit = 1'h0;
		pc1 = req.pc + aabe_pkg::PC_STEP_ONE;
		rel = pc1 + {{4{req.offset[11]}}, req.offset};
		skip_pc = pc1 + (req.next_two_words ? aabe_pkg::PC_STEP_TWO
			: aabe_pkg::PC_STEP_ONE);
		skip_cyc = req.next_two_words ? aabe_pkg::CYC_THREE
			: aabe_pkg::CYC_TWO;
		st_d.rsp = '0;

		rs.done = 1'h1;
		rs.pc_load = 1'h1;
		rs.next_pc = pc1;

		unique case (req.op)
		aabe_pkg::OP_ADD, aabe_pkg::OP_ADD_CARRY: begin
			ar = add8(req.rd_val, req.rr_val,
				(req.op == aabe_pkg::OP_ADD_CARRY) & st_q.status.c);
		end
		aabe_pkg::OP_SUBTRACT, aabe_pkg::OP_COMPARE: begin
			ar = sub8(req.rd_val, req.rr_val, 1'h0);
		end
		aabe_pkg::OP_SUBTRACT_CONSTANT, aabe_pkg::OP_COMPARE_IMMEDIATE: begin
			ar = sub8(req.rd_val, req.imm, 1'h0);
		end
		aabe_pkg::OP_SUBTRACT_WITH_CARRY,
		aabe_pkg::OP_COMPARE_WITH_CARRY: begin
			ar = sub8(req.rd_val, req.rr_val, st_q.status.c);
		end
		aabe_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY: begin
			ar = sub8(req.rd_val, req.imm, st_q.status.c);
		end
		aabe_pkg::OP_AND: begin
			res = req.rd_val & req.rr_val;
		end
		aabe_pkg::OP_TEST_ZERO_MINUS: begin
			res = req.rd_val & req.rd_val;
		end
		aabe_pkg::OP_AND_CONSTANT: begin
			res = req.rd_val & req.imm;
		end
		aabe_pkg::OP_OR: begin
			res = req.rd_val | req.rr_val;
		end
		aabe_pkg::OP_OR_CONSTANT, aabe_pkg::OP_SET_BITS_MASK: begin
			res = req.rd_val | req.imm;
		end
		aabe_pkg::OP_EXCLUSIVE_OR_REGS: begin
			res = req.rd_val ^ req.rr_val;
		end
		aabe_pkg::OP_CLEAR_BITS_MASK: begin
			res = req.rd_val & ~req.imm;
		end
		aabe_pkg::OP_INCREMENT: begin
			res = req.rd_val + aabe_pkg::PC_STEP_ONE[7:0];
		end
		aabe_pkg::OP_DECREMENT: begin
			res = req.rd_val - aabe_pkg::PC_STEP_ONE[7:0];
		end
		default: begin
		end
		endcase

		unique case (req.op)
		aabe_pkg::OP_ADD, aabe_pkg::OP_ADD_CARRY,
		aabe_pkg::OP_SUBTRACT, aabe_pkg::OP_SUBTRACT_CONSTANT,
		aabe_pkg::OP_SUBTRACT_WITH_CARRY,
		aabe_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY,
		aabe_pkg::OP_COMPARE, aabe_pkg::OP_COMPARE_IMMEDIATE,
		aabe_pkg::OP_COMPARE_WITH_CARRY: begin
			sr.h = ar.h;
			sr.v = ar.v;
			sr.n = ar.res[7];
			sr.c = ar.c;
			sr.z = (ar.res == aabe_pkg::BYTE_ZERO);
			if (req.op == aabe_pkg::OP_SUBTRACT_WITH_CARRY
				|| req.op == aabe_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY
				|| req.op == aabe_pkg::OP_COMPARE_WITH_CARRY) begin
				sr.z = sr.z & st_q.status.z;
			end
			rs.byte_we = (req.op != aabe_pkg::OP_COMPARE)
				&& (req.op != aabe_pkg::OP_COMPARE_IMMEDIATE)
				&& (req.op != aabe_pkg::OP_COMPARE_WITH_CARRY);
			rs.byte_res = ar.res;
		end
		aabe_pkg::OP_AND, aabe_pkg::OP_AND_CONSTANT, aabe_pkg::OP_OR,
		aabe_pkg::OP_OR_CONSTANT, aabe_pkg::OP_EXCLUSIVE_OR_REGS,
		aabe_pkg::OP_SET_BITS_MASK, aabe_pkg::OP_CLEAR_BITS_MASK,
		aabe_pkg::OP_TEST_ZERO_MINUS, aabe_pkg::OP_INCREMENT,
		aabe_pkg::OP_DECREMENT: begin
			sr.z = (res == aabe_pkg::BYTE_ZERO);
			sr.n = res[7];
			sr.v = 1'h0;
			if (req.op == aabe_pkg::OP_INCREMENT) begin
				sr.v = (res == aabe_pkg::BYTE_NEG_MIN);
			end
			if (req.op == aabe_pkg::OP_DECREMENT) begin
				sr.v = (res == aabe_pkg::BYTE_POS_MAX);
			end
			rs.byte_we = (req.op != aabe_pkg::OP_TEST_ZERO_MINUS);
			rs.byte_res = res;
		end
		aabe_pkg::OP_ADD_IMMEDIATE_WORD: begin
			wsum = req.word_val + {10'h000, req.word_imm};
			sr.v = ~req.word_val[15] & wsum[15];
			sr.c = req.word_val[15] & ~wsum[15];
			cyc = aabe_pkg::CYC_TWO;
		end
		aabe_pkg::OP_SUBTRACT_IMMEDIATE_WORD: begin
			wsum = req.word_val - {10'h000, req.word_imm};
			sr.v = req.word_val[15] & ~wsum[15];
			sr.c = wsum[15] & ~req.word_val[15];
			cyc = aabe_pkg::CYC_TWO;
		end
		aabe_pkg::OP_MULTIPLY, aabe_pkg::OP_MULTIPLY_SIGNED,
		aabe_pkg::OP_MULTIPLY_SIGNED_UNSIGNED,
		aabe_pkg::OP_FRACTIONAL_MULTIPLY,
		aabe_pkg::OP_FRACTIONAL_MULTIPLY_SIGNED,
		aabe_pkg::OP_FRACTIONAL_MULTIPLY_MIXED: begin
			signed_a = (req.op != aabe_pkg::OP_MULTIPLY)
				&& (req.op != aabe_pkg::OP_FRACTIONAL_MULTIPLY);
			signed_b = (req.op == aabe_pkg::OP_MULTIPLY_SIGNED)
				|| (req.op == aabe_pkg::OP_FRACTIONAL_MULTIPLY_SIGNED);
			frac = (req.op == aabe_pkg::OP_FRACTIONAL_MULTIPLY)
				|| (req.op == aabe_pkg::OP_FRACTIONAL_MULTIPLY_SIGNED)
				|| (req.op == aabe_pkg::OP_FRACTIONAL_MULTIPLY_MIXED);
			ma = {signed_a & req.rd_val[7], req.rd_val};
			mb = {signed_b & req.rr_val[7], req.rr_val};
			prod = $signed(ma) * $signed(mb);
			sr.c = prod[15];
			rs.product = frac ? {prod[14:0], 1'h0} : prod[15:0];
			sr.z = (rs.product == aabe_pkg::WORD_ZERO);
			rs.prod_we = 1'h1;
			cyc = aabe_pkg::CYC_TWO;
		end
		aabe_pkg::OP_RELATIVE_JUMP: begin
			rs.next_pc = rel;
			cyc = aabe_pkg::CYC_TWO;
		end
		aabe_pkg::OP_POINTER_JUMP: begin
			rs.next_pc = req.z_ptr;
			cyc = aabe_pkg::CYC_TWO;
		end
		aabe_pkg::OP_DIRECT_JUMP: begin
			rs.next_pc = req.target;
			cyc = aabe_pkg::CYC_THREE;
		end
		aabe_pkg::OP_RELATIVE_CALL, aabe_pkg::OP_POINTER_CALL: begin
			rs.next_pc = (req.op == aabe_pkg::OP_POINTER_CALL)
				? req.z_ptr : rel;
			rs.push = 1'h1;
			rs.push_addr = pc1;
			cyc = aabe_pkg::CYC_THREE;
		end
		aabe_pkg::OP_DIRECT_CALL: begin
			rs.next_pc = req.target;
			rs.push = 1'h1;
			rs.push_addr = req.pc + aabe_pkg::PC_STEP_TWO;
			cyc = aabe_pkg::CYC_FOUR;
		end
		aabe_pkg::OP_RETURN, aabe_pkg::OP_INTERRUPT_RETURN: begin
			rs.next_pc = req.stack_addr;
			rs.pop = 1'h1;
			if (req.op == aabe_pkg::OP_INTERRUPT_RETURN) begin
				sr.i = 1'h1;
			end
			cyc = aabe_pkg::CYC_FOUR;
		end
		aabe_pkg::OP_COMPARE_SKIP_EQUAL, aabe_pkg::OP_SKIP_REG_BIT_CLEAR,
		aabe_pkg::OP_SKIP_REG_BIT_SET, aabe_pkg::OP_SKIP_IO_BIT_CLEAR,
		aabe_pkg::OP_SKIP_IO_BIT_SET: begin
			unique case (req.op)
			aabe_pkg::OP_COMPARE_SKIP_EQUAL:
				skip = (req.rd_val == req.rr_val);
			aabe_pkg::OP_SKIP_REG_BIT_CLEAR:
				skip = ~req.rr_val[req.bit_sel];
			aabe_pkg::OP_SKIP_REG_BIT_SET:
				skip = req.rr_val[req.bit_sel];
			aabe_pkg::OP_SKIP_IO_BIT_CLEAR:
				skip = ~req.io_val[req.bit_sel];
			default:
				skip = req.io_val[req.bit_sel];
			endcase
			if (skip) begin
				rs.next_pc = skip_pc;
				cyc = skip_cyc;
			end
		end
		default: begin
			unique case (req.op)
			aabe_pkg::OP_BRANCH_STATUS_BIT_SET:
				take = sv[req.bit_sel];
			aabe_pkg::OP_BRANCH_STATUS_BIT_CLEAR:
				take = ~sv[req.bit_sel];
			aabe_pkg::OP_BRANCH_SIGNED_GE:
				take = ~(st_q.status.n ^ st_q.status.v);
			aabe_pkg::OP_BRANCH_SIGNED_LT:
				take = st_q.status.n ^ st_q.status.v;
			aabe_pkg::OP_BRANCH_SAME_OR_HIGHER:
				take = ~st_q.status.c;
			aabe_pkg::OP_BRANCH_LOWER:
				take = st_q.status.c;
			aabe_pkg::OP_BRANCH_HALF_CARRY_SET:
				take = st_q.status.h;
			default:
				take = ~st_q.status.h;
			endcase
			if (take) begin
				rs.next_pc = rel;
				cyc = aabe_pkg::CYC_TWO;
			end
		end
		endcase

		if (req.op == aabe_pkg::OP_ADD_IMMEDIATE_WORD
			|| req.op == aabe_pkg::OP_SUBTRACT_IMMEDIATE_WORD) begin
			sr.n = wsum[15];
			sr.z = (wsum == aabe_pkg::WORD_ZERO);
			sr.s = sr.n ^ sr.v;
			rs.word_we = 1'h1;
			rs.word_res = wsum;
		end

		// --------------------------------------------------------
		// Sequencing
		// --------------------------------------------------------
		unique case (st_q.fsm)
		aabe_pkg::ST_IDLE: begin
			if (req_valid) begin
				if (cyc == aabe_pkg::CYC_ONE) begin
					st_d.rsp = rs;
					st_d.status = sr;
					commit = 1'h1;
				end else begin
					st_d.pend = rs;
					st_d.pend_status = sr;
					st_d.cnt = cyc - aabe_pkg::CYC_ONE;
					st_d.fsm = aabe_pkg::ST_BUSY;
				end
			end
		end
		aabe_pkg::ST_BUSY: begin
			st_d.cnt = st_q.cnt - aabe_pkg::CYC_ONE;
			if (st_q.cnt == aabe_pkg::CYC_ONE) begin
				st_d.rsp = st_q.pend;
				st_d.status = st_q.pend_status;
				st_d.fsm = aabe_pkg::ST_IDLE;
				commit = 1'h1;
			end
		end
		endcase

		// Flag updates by an instruction win over a software write.
		if (reg_wr && reg_addr == aabe_pkg::REG_STATUS && !commit) begin
			st_d.status = reg_wdata;
		end

		ex.busy = (st_q.fsm == aabe_pkg::ST_BUSY);
		ex.remaining = st_q.cnt;
		st_d.rdata = aabe_pkg::BYTE_ZERO;
		if (reg_rd) begin
			if (reg_addr == aabe_pkg::REG_STATUS) begin
				st_d.rdata = st_q.status;
			end else if (reg_addr == aabe_pkg::REG_EXEC) begin
				st_d.rdata = ex;
			end
		end

		st_d.ready = (st_d.fsm == aabe_pkg::ST_IDLE);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.fsm <= aabe_pkg::ST_IDLE;
			st_q.ready <= 1'h1;
			st_q.status <= aabe_pkg::STATUS_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign req_ready = st_q.ready;
	assign rsp = st_q.rsp;
	assign status = st_q.status;
	assign reg_rdata = st_q.rdata;

endmodule

// ===== logic/aabe_pkg.sv
// Types and constants shared by the execution unit for arithmetic,
// logic, multiply, compare, skip, jump, call and branch instructions.
// Assumes a single core clock and a synchronous active-low reset.
package aabe_pkg;

	// --------------------
	// Instruction codes
	// --------------------
	typedef enum logic [5:0] {
		OP_ADD, OP_ADD_CARRY, OP_ADD_IMMEDIATE_WORD,
		OP_SUBTRACT, OP_SUBTRACT_CONSTANT, OP_SUBTRACT_WITH_CARRY,
		OP_SUBTRACT_CONSTANT_WITH_CARRY, OP_SUBTRACT_IMMEDIATE_WORD,
		OP_AND, OP_AND_CONSTANT, OP_OR, OP_OR_CONSTANT,
		OP_EXCLUSIVE_OR_REGS, OP_SET_BITS_MASK, OP_CLEAR_BITS_MASK,
		OP_INCREMENT, OP_DECREMENT, OP_TEST_ZERO_MINUS,
		OP_MULTIPLY, OP_MULTIPLY_SIGNED, OP_MULTIPLY_SIGNED_UNSIGNED,
		OP_FRACTIONAL_MULTIPLY, OP_FRACTIONAL_MULTIPLY_SIGNED,
		OP_FRACTIONAL_MULTIPLY_MIXED,
		OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_DIRECT_JUMP,
		OP_RELATIVE_CALL, OP_POINTER_CALL, OP_DIRECT_CALL,
		OP_RETURN, OP_INTERRUPT_RETURN,
		OP_COMPARE_SKIP_EQUAL, OP_COMPARE, OP_COMPARE_WITH_CARRY,
		OP_COMPARE_IMMEDIATE,
		OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
		OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
		OP_BRANCH_STATUS_BIT_SET, OP_BRANCH_STATUS_BIT_CLEAR,
		OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
		OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER,
		OP_BRANCH_HALF_CARRY_SET, OP_BRANCH_HALF_CARRY_CLEAR
	} aabe_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_BUSY = 2'h2
	} aabe_fsm_t;

	// --------------------
	// Cycle counts
	// --------------------
	localparam logic [2:0] CYC_ONE   = 3'h1;
	localparam logic [2:0] CYC_TWO   = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR  = 3'h4;

	// --------------------
	// Values and register map
	// --------------------
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	localparam logic [7:0]  BYTE_NEG_MIN  = 8'h80;
	localparam logic [7:0]  BYTE_POS_MAX  = 8'h7F;
	localparam logic [15:0] WORD_ZERO     = 16'h0000;
	localparam logic [15:0] PC_STEP_ONE   = 16'h0001;
	localparam logic [15:0] PC_STEP_TWO   = 16'h0002;
	localparam logic [7:0]  STATUS_RESET  = 8'h00;
	localparam logic [1:0]  REG_STATUS    = 2'h0;
	localparam logic [1:0]  REG_EXEC      = 2'h1;

	// --------------------
	// Carriers
	// --------------------
	typedef struct packed {
		logic i; logic t; logic h; logic s;
		logic v; logic n; logic z; logic c;
	} aabe_status_t;

	typedef struct packed {
		logic [3:0] reserved;
		logic [2:0] remaining;
		logic       busy;
	} aabe_exec_t;

	typedef struct packed {
		aabe_op_t    op;
		logic [7:0]  rd_val;
		logic [7:0]  rr_val;
		logic [7:0]  imm;
		logic [15:0] word_val;
		logic [5:0]  word_imm;
		logic [2:0]  bit_sel;
		logic [11:0] offset;
		logic [15:0] target;
		logic [15:0] z_ptr;
		logic [15:0] stack_addr;
		logic [15:0] pc;
		logic [7:0]  io_val;
		logic        next_two_words;
	} aabe_req_t;

	typedef struct packed {
		logic        done;
		logic        byte_we;
		logic [7:0]  byte_res;
		logic        word_we;
		logic [15:0] word_res;
		logic        prod_we;
		logic [15:0] product;
		logic        pc_load;
		logic [15:0] next_pc;
		logic        push;
		logic [15:0] push_addr;
		logic        pop;
	} aabe_rsp_t;

	typedef struct packed {
		logic [7:0] res;
		logic       h;
		logic       v;
		logic       c;
	} aabe_arith_t;

	typedef struct packed {
		aabe_fsm_t    fsm;
		logic [2:0]   cnt;
		logic         ready;
		aabe_rsp_t    rsp;
		aabe_rsp_t    pend;
		aabe_status_t status;
		aabe_status_t pend_status;
		logic [7:0]   rdata;
	} aabe_state_t;

endpackage

// ===== test/aabe_exec_properties.sv
// Concurrent checks on the execution unit, seen from its ports only.
// Assumes one clock domain, ref_clk, with synchronous reset_n.
`timescale 1ns/1ps

module aabe_exec_properties (
	input wire logic                   ref_clk,
	input wire logic                   reset_n,
	input wire logic                   req_valid,
	input wire aabe_pkg::aabe_req_t    req,
	input wire logic                   req_ready,
	input wire aabe_pkg::aabe_rsp_t    rsp,
	input wire aabe_pkg::aabe_status_t status,
	input wire logic [1:0]             reg_addr,
	input wire logic [7:0]             reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata
);
	logic        take;
	logic [15:0] tgt;

	assign take = req_valid && req_ready;
	assign tgt  = req.pc + 16'h0001 + {{4{req.offset[11]}}, req.offset};

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// --------------------
	// Timing and results
	// --------------------
	AST_ADD_ONE: assert property (
		take && req.op == aabe_pkg::OP_ADD |=> rsp.done && rsp.byte_we
		&& rsp.byte_res == $past(req.rd_val) + $past(req.rr_val))
		else $error("Add wrong.");
	AST_WORD_TWO: assert property (
		take && req.op == aabe_pkg::OP_ADD_IMMEDIATE_WORD |=> !rsp.done
		##1 rsp.done && rsp.word_we
		&& rsp.word_res == $past(req.word_val, 2) + $past(req.word_imm, 2))
		else $error("Word add wrong.");
	AST_MUL_TWO: assert property (
		take && req.op == aabe_pkg::OP_MULTIPLY |=> !rsp.done && !req_ready
		##1 rsp.done && rsp.prod_we
		&& rsp.product == $past(req.rd_val, 2) * $past(req.rr_val, 2))
		else $error("Multiply wrong.");
	AST_DCALL_FOUR: assert property (
		take && req.op == aabe_pkg::OP_DIRECT_CALL |=> !rsp.done [*3]
		##1 rsp.done && rsp.push && rsp.push_addr == $past(req.pc, 4) + 16'h0002)
		else $error("Direct call wrong.");
	AST_INTERRUPT_RETURN_FOUR: assert property (
		take && req.op == aabe_pkg::OP_INTERRUPT_RETURN |=> !rsp.done [*3]
		##1 rsp.done && rsp.pop && status.i)
		else $error("Interrupt return wrong.");
	AST_JMP_THREE: assert property (
		take && req.op == aabe_pkg::OP_DIRECT_JUMP |=> !rsp.done [*2]
		##1 rsp.done && rsp.next_pc == $past(req.target, 3))
		else $error("Direct jump wrong.");
	AST_BR_TAKEN: assert property (
		take && req.op == aabe_pkg::OP_BRANCH_SIGNED_LT
		&& (status.n ^ status.v) |=> !rsp.done ##1 rsp.done
		&& rsp.next_pc == $past(tgt, 2) && status == $past(status, 2))
		else $error("Taken branch wrong.");

	// --------------------
	// Flags
	// --------------------
	AST_INC_KEEP_C: assert property (
		take && req.op inside {aabe_pkg::OP_INCREMENT, aabe_pkg::OP_DECREMENT}
		|=> rsp.done && $stable(status.c))
		else $error("Carry touched.");
	AST_LOGIC_FLAGS: assert property (
		take && req.op inside {aabe_pkg::OP_AND, aabe_pkg::OP_OR,
		aabe_pkg::OP_EXCLUSIVE_OR_REGS} |=> $stable(status.c)
		&& $stable(status.h) && !status.v
		&& status.z == (rsp.byte_res == 8'h00))
		else $error("Logic flags wrong.");
	AST_CMP_NOSTORE: assert property (
		take && req.op inside {aabe_pkg::OP_COMPARE,
		aabe_pkg::OP_COMPARE_IMMEDIATE, aabe_pkg::OP_COMPARE_WITH_CARRY}
		|=> rsp.done && !rsp.byte_we)
		else $error("Compare stored.");

	COV_ADD: cover property (take && req.op == aabe_pkg::OP_ADD);
	COV_MUL: cover property (rsp.done && rsp.prod_we);
	COV_CALL: cover property (rsp.done && rsp.push);
endmodule

bind aabe_exec aabe_exec_properties u_props (
	.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .rsp(rsp), .status(status),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

// ===== test/aabe_fetch_model.sv
// Fetch stage and register file model: follows the unit's responses.
// Assumes it shares ref_clk and reset_n with the unit.
`timescale 1ns/1ps

module aabe_fetch_model (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire aabe_pkg::aabe_rsp_t rsp,
	output logic [15:0]              pc_q,
	output logic [15:0]              pair_q
);
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pc_q   <= 16'h0000;
			pair_q <= 16'h0000;
		end else if (rsp.done) begin
			if (rsp.pc_load) begin
				pc_q <= rsp.next_pc;
			end
			if (rsp.prod_we) begin
				pair_q <= rsp.product;
			end
		end
	end
endmodule

// ===== test/tb.sv
// Testbench for the execution unit: register accesses and instructions.
// Assumes the package, the unit, the checker and the model compile first.
`timescale 1ns/1ps

module tb;
	logic                   ref_clk;
	logic                   reset_n;
	logic                   req_valid;
	aabe_pkg::aabe_req_t    req;
	aabe_pkg::aabe_req_t    rq;
	logic                   req_ready;
	aabe_pkg::aabe_rsp_t    rsp;
	aabe_pkg::aabe_status_t status;
	logic [1:0]             reg_addr;
	logic [7:0]             reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [7:0]             reg_rdata;
	logic [7:0]             rdat;
	logic [15:0]            m_pc;
	logic [15:0]            m_pair;
	int                     bad_count;
	int                     n_tests;

	aabe_exec uut (.ref_clk(ref_clk), .reset_n(reset_n),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp(rsp), .status(status), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	aabe_fetch_model partner (.ref_clk(ref_clk), .reset_n(reset_n),
		.rsp(rsp), .pc_q(m_pc), .pair_q(m_pair));

	always #20 ref_clk = ~ref_clk;

	// --------------------
	// Tasks
	// --------------------
	task automatic complete_run();
		$display("Checks: %0d, mismatches: %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [15:0] exp, logic [15:0] seen);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic reg_write(logic [1:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(logic [1:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	function automatic logic [15:0] pick(aabe_pkg::aabe_rsp_t r);
		return r.byte_we ? {8'h00, r.byte_res} : r.word_we ? r.word_res
			: r.prod_we ? r.product : r.push ? r.push_addr : 16'h0000;
	endfunction

	// Operands {rd, rr or constant, starting status}.
	// Expected {next pc, written value, status after}.
	task automatic ex(aabe_pkg::aabe_op_t op, logic [23:0] ops, int n,
		logic [39:0] exp);
		int k;
		reg_write(2'h0, ops[7:0]);
		rq.op     = op;
		rq.rd_val = ops[23:16];
		rq.io_val = ops[23:16];
		rq.rr_val = ops[15:8];
		rq.imm    = ops[15:8];
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req       <= rq;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		#1;
		k = 1;
		while (rsp.done !== 1'b1 && k < 8) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		if (rsp.done !== 1'b1) begin
			bad_count++;
			complete_run();
		end
		chk("cycles", 16'(n), 16'(k));
		chk("next_pc", exp[39:24], rsp.next_pc);
		chk("result", exp[23:8], pick(rsp));
		chk("status", {8'h00, exp[7:0]}, {8'h00, status});
	endtask

	// --------------------
	// Sequence
	// --------------------
	initial begin
		ref_clk   = 1'b0;
		reset_n   = 1'b0;
		req_valid = 1'b0;
		req       = '0;
		rq        = '0;
		reg_addr  = 2'h0;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		bad_count = 0;
		n_tests   = 0;
		rq.pc         = 16'h0100;
		rq.offset     = 12'hFFE;
		rq.z_ptr      = 16'h1234;
		rq.target     = 16'h4000;
		rq.stack_addr = 16'h2222;
		rq.bit_sel    = 3'h3;
		rq.word_imm   = 6'h01;
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		#1;
		chk("ready", 16'h0001, {15'h0000, req_ready});
		chk("status", 16'h0000, {8'h00, status});
		reg_read(2'h0, rdat);
		chk("rd_status", 16'h0000, {8'h00, rdat});
		reg_write(2'h1, 8'hFF);
		reg_read(2'h1, rdat);
		chk("rd_exec", 16'h0000, {8'h00, rdat});
		reg_read(2'h3, rdat);
		chk("rd_unmapped", 16'h0000, {8'h00, rdat});
		reg_write(2'h0, 8'hA5);
		reg_read(2'h0, rdat);
		chk("rd_status", 16'h00A5, {8'h00, rdat});
		ex(aabe_pkg::OP_ADD, 24'h0F0100, 1, 40'h0101_0010_20);
		ex(aabe_pkg::OP_ADD_CARRY, 24'h7F0001, 1, 40'h0101_0080_2C);
		ex(aabe_pkg::OP_SUBTRACT, 24'h100100, 1, 40'h0101_000F_20);
		ex(aabe_pkg::OP_SUBTRACT_CONSTANT, 24'h000100, 1,
			40'h0101_00FF_25);
		ex(aabe_pkg::OP_SUBTRACT_WITH_CARRY, 24'h050403, 1,
			40'h0101_0000_02);
		ex(aabe_pkg::OP_SUBTRACT_CONSTANT_WITH_CARRY, 24'h050401, 1,
			40'h0101_0000_00);
		rq.word_val = 16'hFFFF;
		ex(aabe_pkg::OP_ADD_IMMEDIATE_WORD, 24'h000000, 2,
			40'h0101_0000_03);
		rq.word_val = 16'h0000;
		ex(aabe_pkg::OP_SUBTRACT_IMMEDIATE_WORD, 24'h000000, 2,
			40'h0101_FFFF_15);
		ex(aabe_pkg::OP_AND, 24'hF00F29, 1, 40'h0101_0000_23);
		ex(aabe_pkg::OP_OR, 24'h800123, 1, 40'h0101_0081_25);
		ex(aabe_pkg::OP_EXCLUSIVE_OR_REGS, 24'hFF0F08, 1,
			40'h0101_00F0_04);
		ex(aabe_pkg::OP_AND_CONSTANT, 24'h3C0F00, 1, 40'h0101_000C_00);
		ex(aabe_pkg::OP_OR_CONSTANT, 24'h000000, 1, 40'h0101_0000_02);
		ex(aabe_pkg::OP_SET_BITS_MASK, 24'h018000, 1, 40'h0101_0081_04);
		ex(aabe_pkg::OP_CLEAR_BITS_MASK, 24'hFF0F00, 1,
			40'h0101_00F0_04);
		ex(aabe_pkg::OP_TEST_ZERO_MINUS, 24'h800009, 1,
			40'h0101_0000_05);
		ex(aabe_pkg::OP_INCREMENT, 24'h7F0001, 1, 40'h0101_0080_0D);
		ex(aabe_pkg::OP_DECREMENT, 24'h000001, 1, 40'h0101_00FF_05);
		ex(aabe_pkg::OP_MULTIPLY, 24'hFFFF00, 2, 40'h0101_FE01_01);
		ex(aabe_pkg::OP_MULTIPLY_SIGNED, 24'hFFFF00, 2,
			40'h0101_0001_00);
		ex(aabe_pkg::OP_MULTIPLY_SIGNED_UNSIGNED, 24'hFF0200, 2,
			40'h0101_FFFE_01);
		ex(aabe_pkg::OP_FRACTIONAL_MULTIPLY, 24'h808000, 2,
			40'h0101_8000_00);
		ex(aabe_pkg::OP_FRACTIONAL_MULTIPLY_SIGNED, 24'h808000, 2,
			40'h0101_8000_00);
		ex(aabe_pkg::OP_FRACTIONAL_MULTIPLY_MIXED, 24'hFF8000, 2,
			40'h0101_FF00_01);
		@(posedge ref_clk);
		#1;
		chk("pair", 16'hFF00, m_pair);
		ex(aabe_pkg::OP_RELATIVE_JUMP, 24'h00005A, 2, 40'h00FF_0000_5A);
		ex(aabe_pkg::OP_POINTER_JUMP, 24'h00005A, 2, 40'h1234_0000_5A);
		ex(aabe_pkg::OP_DIRECT_JUMP, 24'h00005A, 3, 40'h4000_0000_5A);
		ex(aabe_pkg::OP_RELATIVE_CALL, 24'h00005A, 3, 40'h00FF_0101_5A);
		ex(aabe_pkg::OP_POINTER_CALL, 24'h00005A, 3, 40'h1234_0101_5A);
		ex(aabe_pkg::OP_DIRECT_CALL, 24'h00005A, 4, 40'h4000_0102_5A);
		ex(aabe_pkg::OP_RETURN, 24'h00005A, 4, 40'h2222_0000_5A);
		ex(aabe_pkg::OP_INTERRUPT_RETURN, 24'h00005A, 4,
			40'h2222_0000_DA);
		@(posedge ref_clk);
		#1;
		chk("model_pc", 16'h2222, m_pc);
		ex(aabe_pkg::OP_COMPARE_SKIP_EQUAL, 24'h555500, 2,
			40'h0102_0000_00);
		ex(aabe_pkg::OP_COMPARE_SKIP_EQUAL, 24'h555400, 1,
			40'h0101_0000_00);
		ex(aabe_pkg::OP_COMPARE, 24'h050500, 1, 40'h0101_0000_02);
		ex(aabe_pkg::OP_COMPARE_IMMEDIATE, 24'h050600, 1,
			40'h0101_0000_25);
		ex(aabe_pkg::OP_COMPARE_WITH_CARRY, 24'h050503, 1,
			40'h0101_0000_25);
		ex(aabe_pkg::OP_SKIP_REG_BIT_CLEAR, 24'h000000, 2,
			40'h0102_0000_00);
		ex(aabe_pkg::OP_SKIP_REG_BIT_SET, 24'h000000, 1,
			40'h0101_0000_00);
		ex(aabe_pkg::OP_SKIP_IO_BIT_CLEAR, 24'h080000, 1,
			40'h0101_0000_00);
		rq.next_two_words = 1'b1;
		ex(aabe_pkg::OP_SKIP_IO_BIT_SET, 24'h080000, 3,
			40'h0103_0000_00);
		ex(aabe_pkg::OP_COMPARE_SKIP_EQUAL, 24'h555500, 3,
			40'h0103_0000_00);
		rq.next_two_words = 1'b0;
		ex(aabe_pkg::OP_BRANCH_STATUS_BIT_SET, 24'h000008, 2,
			40'h00FF_0000_08);
		ex(aabe_pkg::OP_BRANCH_STATUS_BIT_CLEAR, 24'h000008, 1,
			40'h0101_0000_08);
		ex(aabe_pkg::OP_BRANCH_SIGNED_GE, 24'h00000C, 2,
			40'h00FF_0000_0C);
		ex(aabe_pkg::OP_BRANCH_SIGNED_LT, 24'h00000C, 1,
			40'h0101_0000_0C);
		ex(aabe_pkg::OP_BRANCH_SIGNED_LT, 24'h000004, 2,
			40'h00FF_0000_04);
		ex(aabe_pkg::OP_BRANCH_SAME_OR_HIGHER, 24'h000000, 2,
			40'h00FF_0000_00);
		ex(aabe_pkg::OP_BRANCH_LOWER, 24'h000000, 1, 40'h0101_0000_00);
		ex(aabe_pkg::OP_BRANCH_HALF_CARRY_SET, 24'h000020, 2,
			40'h00FF_0000_20);
		ex(aabe_pkg::OP_BRANCH_HALF_CARRY_CLEAR, 24'h000020, 1,
			40'h0101_0000_20);
		complete_run();
	end
endmodule
